// >>> hw/pipelined_sync_sram_port.sv
// Pipelined synchronous static memory port, device side of the pins
`timescale 1ns/1ps
// Contract
// - Load with any enable false starts deselect
// - Deselect finishes pending work, tri-states two later
// - Selected only with all three enables true
// - High enable acts like low ones, inverted
// - All synchronous pins act on rising edge
// - Read and write data registered, 36 bits wide
// - Order select high interleaved, low linear
// - Output enable high tri-states pins at once
// - Bus direction handled internally per cycle
// - Sleep input gates internal clock
// - Stored contents kept through sleep
// - Low loads, high advances, deselected low ends
// - Data transfer two cycles after load
// - Clock gate high freezes all but the sleep and order sync flops
// - Lane strobes per word, written two later
module pipelined_sync_sram_port #(
	parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF
) (
	// Clock and reset
	input  wire logic                                  clk,
	input  wire logic                                  rstn,
	// Address and control
	input  wire logic [ADDR_W-1:0]                     addr,
	input  wire logic                                  chip_sel1_n,
	input  wire logic                                  chip_sel_high,
	input  wire logic                                  chip_sel2_n,
	input  wire logic                                  load_or_advance,
	input  wire logic                                  read_write,
	input  wire logic                                  clock_gate_n,
	input  wire logic [sram_port_pkg::LANES-1:0]       byte_lane_write_n,
	// Static and asynchronous controls
	input  wire logic                                  burst_order_sel,
	input  wire logic                                  output_en_n,
	input  wire logic                                  sleep_req,
	// Data pins, split into input, output and enable
	input  wire logic [sram_port_pkg::DATA_W-1:0]      data_bus_in,
	input  wire logic [sram_port_pkg::PAR_W-1:0]       parity_bus_in,
	output logic      [sram_port_pkg::DATA_W-1:0]      data_bus_out,
	output logic      [sram_port_pkg::PAR_W-1:0]       parity_bus_out,
	output logic                                       data_oe_n,
	// Status
	output logic                                       sleeping
);

	typedef struct packed {
		logic                                  sleep_meta;
		logic                                  sleep_sync;
		logic                                  order_meta;
		logic                                  order_sync;
		sram_port_pkg::burst_state_type        burst_state;
		logic [ADDR_W-1:0]                     base_addr;
		logic [sram_port_pkg::STEP_W-1:0]      step;
		logic                                  burst_read;
		logic                                  p1_valid;
		logic                                  p1_read;
		logic [ADDR_W-1:0]                     p1_addr;
		logic [sram_port_pkg::LANES-1:0]       p1_lane_n;
		logic                                  p2_valid;
		logic                                  p2_read;
		logic [ADDR_W-1:0]                     p2_addr;
		logic [sram_port_pkg::LANES-1:0]       p2_lane_n;
		logic [sram_port_pkg::WORD_W-1:0]      rdata;
		logic                                  drive;
	} state_type;

	state_type                             state_reg;
	state_type                             state_next;
	logic                                  run;
	logic                                  selected;
	logic [sram_port_pkg::STEP_W-1:0]      step_next;
	logic                                  mem_wr_en;
	logic [sram_port_pkg::LANES-1:0]       mem_lane_we;
	logic [sram_port_pkg::WORD_W-1:0]      mem_wr_data;
	logic [sram_port_pkg::WORD_W-1:0]      mem_rd_data;

	function automatic logic chip_selected(
		input logic sel1_n,
		input logic sel_high,
		input logic sel2_n
	);
		chip_selected = !sel1_n && sel_high && !sel2_n;
	endfunction

	function automatic logic [sram_port_pkg::STEP_W-1:0] burst_step(
		input logic [sram_port_pkg::STEP_W-1:0] start,
		input logic [sram_port_pkg::STEP_W-1:0] count,
		input logic                             interleave
	);
		// Wraps inside the aligned group of four
		if (interleave) begin
			burst_step = start ^ count;
		end else begin
			burst_step = sram_port_pkg::STEP_W'(start + count);
		end
	endfunction

	// Clock gate or sleep both stand for a missing edge
	assign run       = !clock_gate_n && !state_reg.sleep_sync;
	assign selected  = chip_selected(chip_sel1_n, chip_sel_high, chip_sel2_n);
	assign step_next = sram_port_pkg::STEP_W'(state_reg.step + 2'h1);

	// Write data is taken straight off the pins at the data edge
	assign mem_wr_en   = run && state_reg.p2_valid && !state_reg.p2_read;
	assign mem_lane_we = ~state_reg.p2_lane_n;
	assign mem_wr_data = {parity_bus_in, data_bus_in};

	sram_word_array #(
		.ADDR_W (ADDR_W)
	) u_array (
		.clk     (clk),
		.wr_en   (mem_wr_en),
		.lane_we (mem_lane_we),
		.wr_addr (state_reg.p2_addr),
		.wr_data (mem_wr_data),
		.rd_addr (state_reg.p2_addr),
		.rd_data (mem_rd_data)
	);

	always_comb begin
		state_next = state_reg;
		// Asynchronous sleep and static order pins pass two flops
		state_next.sleep_meta = sleep_req;
		state_next.sleep_sync = state_reg.sleep_meta;
		state_next.order_meta = burst_order_sel;
		state_next.order_sync = state_reg.order_meta;
		if (run) begin
			state_next.p1_valid  = 1'b0;
			state_next.p1_lane_n = sram_port_pkg::LANES_OFF_N;
			if (!load_or_advance) begin
				if (selected) begin
					// New address and direction
					state_next.burst_state = sram_port_pkg::BURST_ACTIVE;
					state_next.base_addr   = addr;
					state_next.step        = sram_port_pkg::STEP_RESET;
					state_next.burst_read  = read_write;
					state_next.p1_valid    = 1'b1;
					state_next.p1_read     = read_write;
					state_next.p1_addr     = addr;
					if (read_write != sram_port_pkg::RW_READ) begin
						state_next.p1_lane_n = byte_lane_write_n;
					end
				end else begin
					// Deselect ends any burst, pending stages drain on
					state_next.burst_state = sram_port_pkg::BURST_IDLE;
				end
			end else if (state_reg.burst_state == sram_port_pkg::BURST_ACTIVE) begin
				// Advance ignores the address pins
				state_next.step     = step_next;
				state_next.p1_valid = 1'b1;
				state_next.p1_read  = state_reg.burst_read;
				state_next.p1_addr  = {state_reg.base_addr[ADDR_W-1:sram_port_pkg::STEP_W],
					burst_step(state_reg.base_addr[sram_port_pkg::STEP_W-1:0],
						step_next, state_reg.order_sync)};
				if (state_reg.burst_read != sram_port_pkg::RW_READ) begin
					state_next.p1_lane_n = byte_lane_write_n;
				end
			end
			// Second stage, then the data edge
			state_next.p2_valid  = state_reg.p1_valid;
			state_next.p2_read   = state_reg.p1_read;
			state_next.p2_addr   = state_reg.p1_addr;
			state_next.p2_lane_n = state_reg.p1_lane_n;
			state_next.drive     = state_reg.p2_valid && state_reg.p2_read;
			if (state_reg.p2_valid && state_reg.p2_read) begin
				state_next.rdata = mem_rd_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg             <= '0;
			state_reg.burst_state <= sram_port_pkg::BURST_IDLE;
			state_reg.step        <= sram_port_pkg::STEP_RESET;
			state_reg.p1_lane_n   <= sram_port_pkg::LANES_OFF_N;
			state_reg.p2_lane_n   <= sram_port_pkg::LANES_OFF_N;
			state_reg.rdata       <= sram_port_pkg::RDATA_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign data_bus_out   = state_reg.rdata[sram_port_pkg::DATA_W-1:0];
	assign parity_bus_out = state_reg.rdata[sram_port_pkg::WORD_W-1:sram_port_pkg::PAR_LSB];
	// Pin enable releases without waiting for a clock edge
	assign data_oe_n      = output_en_n || !state_reg.drive;
	assign sleeping       = state_reg.sleep_sync;

	sequence load_read_seq;
		run && !load_or_advance && selected && (read_write == sram_port_pkg::RW_READ);
	endsequence

	sequence load_write_seq;
		run && !load_or_advance && selected && (read_write != sram_port_pkg::RW_READ);
	endsequence

	sequence desel_seq;
		run && !load_or_advance && !selected;
	endsequence

	sequence two_more_edges;
		##1 run ##1 run;
	endsequence

	AST_DESELECT_TRISTATE: assert property (@(posedge clk) disable iff (!rstn)
		desel_seq ##0 two_more_edges |=> (data_oe_n && !state_reg.drive))
		else $error("bus still driven two cycles after deselect");

	AST_READ_DRIVES: assert property (@(posedge clk) disable iff (!rstn)
		load_read_seq ##0 two_more_edges |=> (state_reg.drive && (data_oe_n == output_en_n)))
		else $error("read data not driven two cycles after load");

	AST_WRITE_TIMING: assert property (@(posedge clk) disable iff (!rstn)
		load_write_seq ##0 two_more_edges |-> (mem_wr_en && (mem_lane_we == ~$past(byte_lane_write_n, 2))))
		else $error("write not performed two cycles after load");

	AST_WRITE_RELEASES_BUS: assert property (@(posedge clk) disable iff (!rstn)
		load_write_seq ##0 two_more_edges |=> !state_reg.drive)
		else $error("bus driven during a write data cycle");

	AST_OE_ASYNC: assert property (@(posedge clk) disable iff (!rstn)
		output_en_n |-> data_oe_n)
		else $error("data pins driven with output enable high");

	AST_FREEZE: assert property (@(posedge clk) disable iff (!rstn)
		clock_gate_n |=> ($stable(state_reg.rdata) && $stable(state_reg.drive) &&
			$stable(state_reg.p2_addr) && $stable(state_reg.step) && $stable(state_reg.p1_valid)))
		else $error("state moved while clock gate was high");

	AST_SLEEP_KEEPS: assert property (@(posedge clk) disable iff (!rstn)
		state_reg.sleep_sync |-> (!mem_wr_en && !run))
		else $error("array written during sleep");

	AST_SELECT_LOADS: assert property (@(posedge clk) disable iff (!rstn)
		run && !load_or_advance |=> (state_reg.p1_valid == $past(selected)))
		else $error("load cycle and chip enables disagree");

	AST_READ_NO_STROBE: assert property (@(posedge clk) disable iff (!rstn)
		state_reg.p1_valid && state_reg.p1_read |-> (state_reg.p1_lane_n == sram_port_pkg::LANES_OFF_N))
		else $error("lane strobes kept on a read");

	AST_BURST_STEP: assert property (@(posedge clk) disable iff (!rstn)
		run && load_or_advance && (state_reg.burst_state == sram_port_pkg::BURST_ACTIVE)
		|=> (state_reg.p1_valid && (state_reg.step == $past(step_next)) &&
			(state_reg.p1_addr[1:0] == ($past(state_reg.order_sync) ?
				($past(state_reg.base_addr[1:0]) ^ state_reg.step) :
				2'($past(state_reg.base_addr[1:0]) + state_reg.step)))))
		else $error("burst address stepped wrongly");

	AST_DESEL_ENDS_BURST: assert property (@(posedge clk) disable iff (!rstn)
		desel_seq ##1 (run && load_or_advance) |=> !state_reg.p1_valid)
		else $error("advance issued after burst was ended");

endmodule

// >>> hw/sram_port_pkg.sv
// Constants and types shared by the pipelined memory port
package sram_port_pkg;

	// Word layout: 32 data bits in the low part, one parity bit per lane above
	localparam int DATA_W     = 32;
	localparam int PAR_W      = 4;
	localparam int LANES      = 4;
	localparam int BYTE_W     = 8;
	localparam int LANE_W     = BYTE_W + 1;
	localparam int WORD_W     = DATA_W + PAR_W;
	localparam int PAR_LSB    = DATA_W;

	// Depth of the array: 256K words
	localparam int ADDR_W_DEF = 18;

	// Burst counter: four words, two low address bits step
	localparam int STEP_W     = 2;
	localparam int BURST_LEN  = 4;

	// Cycles from a load or deselect edge to the data edge
	localparam int PIPE_DEPTH = 2;

	// Read/write pin level that means read
	localparam logic RW_READ       = 1'b1;
	// Reset values
	localparam logic [STEP_W-1:0] STEP_RESET  = 2'h0;
	localparam logic [LANES-1:0]  LANES_OFF_N = 4'hF;
	localparam logic [WORD_W-1:0] RDATA_RESET = 36'h0;

	typedef enum logic [1:0] {
		BURST_IDLE   = 2'h1,
		BURST_ACTIVE = 2'h2
	} burst_state_type;

endpackage

// >>> hw/sram_word_array.sv
// Storage array with per-lane write and combinational read
`timescale 1ns/1ps
module sram_word_array #(
	parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF
) (
	// Clock
	input  wire logic                             clk,
	// Write side
	input  wire logic                             wr_en,
	input  wire logic [sram_port_pkg::LANES-1:0]  lane_we,
	input  wire logic [ADDR_W-1:0]                wr_addr,
	input  wire logic [sram_port_pkg::WORD_W-1:0] wr_data,
	// Read side
	input  wire logic [ADDR_W-1:0]                rd_addr,
	output logic      [sram_port_pkg::WORD_W-1:0] rd_data
);

	logic [sram_port_pkg::WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Contents are never cleared: they survive reset and sleep
	always_ff @(posedge clk) begin
		if (wr_en) begin
			for (int i = 0; i < sram_port_pkg::LANES; i++) begin
				if (lane_we[i]) begin
					mem[wr_addr][i*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W] <=
						wr_data[i*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W];
					mem[wr_addr][sram_port_pkg::PAR_LSB + i] <=
						wr_data[sram_port_pkg::PAR_LSB + i];
				end
			end
		end
	end

	assign rd_data = mem[rd_addr];

endmodule

// >>> tb/mem_ctrl_model.sv
// Memory controller model driving the command and write-data pins
`timescale 1ns/1ps
module mem_ctrl_model #(
	parameter int AW = 6
) (
	// Clock
	input  wire logic        clk,
	// Command pins
	output logic [AW-1:0]    addr,
	output logic [2:0]       sel,
	output logic             lo_adv,
	output logic             rw,
	output logic             gate_n,
	output logic [3:0]       lanes_n,
	// Data pins
	input  wire logic [35:0] dev_word,
	input  wire logic        dev_oe_n,
	output logic [35:0]      pin
);
	logic [35:0] wd, d1, d2, flt;
	logic        w1, w2, bw;
	// Released bus shows the inverse of its last level
	assign pin = !dev_oe_n ? dev_word : (w2 ? d2 : flt);
	initial begin
		{addr, sel, lo_adv, rw, gate_n, lanes_n} = {{AW{1'b0}}, 3'h5, 1'b0, 1'b1, 1'b0, 4'hF};
		{wd, d1, d2, flt, w1, w2, bw} = 147'h0;
	end
	// Write data follows its command by two taken edges
	always @(posedge clk) begin
		flt <= ~pin;
		if (!gate_n) begin
			if (!lo_adv)
				bw <= sel == 3'h2 && rw != sram_port_pkg::RW_READ;
			w1 <= lo_adv ? bw : (sel == 3'h2 && rw != sram_port_pkg::RW_READ);
			d1 <= wd;
			w2 <= w1;
			d2 <= d1;
		end
	end
	task automatic issue(input logic l, input logic [2:0] s, input logic r, input logic [3:0] n,
		input logic [AW-1:0] a, input logic [35:0] d, input logic g);
		@(posedge clk);
		lo_adv <= l;
		sel <= s;
		rw <= r;
		lanes_n <= n;
		addr <= a;
		wd <= d;
		gate_n <= g;
	endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the pipelined memory port
`timescale 1ns/1ps
module tb_top;
	localparam int AW = 6;
	typedef struct packed {logic v; logic rd; logic [AW-1:0] a; logic [3:0] ln;} stage_type;
	logic          clk, rstn, oe_n, sleep_req, order, lo_adv, rw, gate_n, data_oe_n, sleeping;
	logic [AW-1:0] addr, base;
	logic [2:0]    sel;
	logic [3:0]    lanes_n, parity_bus_out;
	logic [31:0]   data_bus_out;
	logic [35:0]   pin, expq;
	logic [35:0]   mem [64];
	logic [2:0]    pats [3] = '{3'h6, 3'h0, 3'h3};
	logic [1:0]    cnt, sl;
	logic          drv, bact, brd;
	stage_type     p1, p2;
	int            failures = 0;
	int            checked = 0;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	mem_ctrl_model #(.AW(AW)) i_ctrl (.clk(clk), .addr(addr), .sel(sel), .lo_adv(lo_adv), .rw(rw),
		.gate_n(gate_n), .lanes_n(lanes_n), .dev_word({parity_bus_out, data_bus_out}),
		.dev_oe_n(data_oe_n), .pin(pin));
	pipelined_sync_sram_port #(.ADDR_W(AW)) i_dut (.clk(clk), .rstn(rstn), .addr(addr),
		.chip_sel1_n(sel[2]), .chip_sel_high(sel[1]), .chip_sel2_n(sel[0]),
		.load_or_advance(lo_adv), .read_write(rw), .clock_gate_n(gate_n),
		.byte_lane_write_n(lanes_n), .burst_order_sel(order), .output_en_n(oe_n),
		.sleep_req(sleep_req), .data_bus_in(pin[31:0]), .parity_bus_in(pin[35:32]),
		.data_bus_out(data_bus_out), .parity_bus_out(parity_bus_out),
		.data_oe_n(data_oe_n), .sleeping(sleeping));
	// Reference pipeline, sampling the pins as the device does
	always @(posedge clk) begin
		if (!rstn) begin
			{sl, drv, bact, p1, p2} = 28'h0;
			expq = sram_port_pkg::RDATA_RESET;
		end else begin
			if (!gate_n && !sl[1]) begin
				if (p2.v && p2.rd)
					expq = mem[p2.a];
				for (int i = 0; i < 4; i++)
					if (p2.v && !p2.rd && !p2.ln[i])
						{mem[p2.a][32+i], mem[p2.a][8*i+:8]} = {pin[32+i], pin[8*i+:8]};
				drv = p2.v && p2.rd;
				p2 = p1;
				if (!lo_adv) begin
					bact = sel == 3'h2;
					base = addr;
					brd = rw == sram_port_pkg::RW_READ;
					cnt = 2'h0;
				end else
					cnt = cnt + 2'h1;
				p1 = '{bact, brd, {base[AW-1:2], order ? base[1:0] ^ cnt : base[1:0] + cnt},
					lanes_n};
			end
			sl = {sl[0], sleep_req};
		end
	end
	always @(negedge clk)
		if (rstn) begin
			check("drive", {35'h0, data_oe_n}, {35'h0, oe_n | !drv});
			check("rdata", {parity_bus_out, data_bus_out}, expq);
			check("sleep", {35'h0, sleeping}, {35'h0, sl[1]});
		end
	task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [35:0] v, input logic [3:0] n);
		i_ctrl.issue(1'b0, 3'h2, ~sram_port_pkg::RW_READ, n, a, v, 1'b0);
	endtask
	task automatic rd(input logic [AW-1:0] a);
		i_ctrl.issue(1'b0, 3'h2, sram_port_pkg::RW_READ, 4'h0, a, 36'h0, 1'b0);
	endtask
	task automatic adv(input logic [35:0] v);
		i_ctrl.issue(1'b1, 3'h2, 1'b0, 4'h0, 6'h0, v, 1'b0);
	endtask
	task automatic idle(input int c);
		repeat (c) i_ctrl.issue(1'b0, 3'h5, 1'b1, 4'hF, 6'h0, 36'h0, 1'b0);
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{rstn, oe_n, sleep_req, order} = 4'h0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		// Whole words back to back, a two-lane merge, reads with strobes low
		for (int k = 0; k < 4; k++)
			wr(6'h10 + 6'(k), {4'(k), 28'hC0DE000, 4'(k)}, 4'h0);
		wr(6'h11, 36'hF_FFFF_FFFF, 4'h5);
		for (int k = 0; k < 4; k++)
			rd(6'h10 + 6'(k));
		// Each enable alone deselects; the next advance finds no burst
		foreach (pats[k]) begin
			rd(6'h13);
			i_ctrl.issue(1'b0, pats[k], 1'b1, 4'h0, 6'h10, 36'h0, 1'b0);
			adv(36'h0);
			idle(2);
		end
		// Linear burst from slot two, read back past the wrap
		wr(6'h22, 36'h1_1111_1111, 4'h0);
		for (int k = 2; k < 5; k++)
			adv({9{4'(k)}});
		idle(1);
		rd(6'h22);
		repeat (5) adv(36'h0);
		idle(2);
		// Order select moves only while reset holds the port
		rstn <= 1'b0;
		order <= 1'b1;
		idle(4);
		rstn <= 1'b1;
		idle(3);
		rd(6'h21);
		repeat (3) adv(36'h0);
		idle(1);
		// Frozen edges ignore a write load and stretch the read
		rd(6'h10);
		repeat (3) i_ctrl.issue(1'b0, 3'h2, 1'b0, 4'h0, 6'h11, 36'h0, 1'b1);
		idle(3);
		rd(6'h12);
		oe_n <= 1'b1;
		idle(3);
		oe_n <= 1'b0;
		idle(1);
		sleep_req <= 1'b1;
		repeat (6) rd(6'h13);
		sleep_req <= 1'b0;
		idle(4);
		rd(6'h11);
		idle(3);
		end_sim;
	end
	// Run needs about 80 cycles
	initial begin
		repeat (1000) @(posedge clk);
		failures++;
		end_sim;
	end
endmodule
